// ### rtl/mbcpb_consts.vh
/*
  Constants of the coil-controlled fieldbus bridge: register offsets, field
  positions, reset values, meter command codes and terminator characters.
  Included by the bridge module, the port checker and the bench top.
*/
`ifndef MBCPB_CONSTS_VH
`define MBCPB_CONSTS_VH
`define MBCPB_A_OUT 8'h00
`define MBCPB_A_RST 8'h04
`define MBCPB_A_POLL 8'h08
`define MBCPB_A_TERM 8'h0c
`define MBCPB_A_CTRL 8'h10
`define MBCPB_A_MAN 8'h14
`define MBCPB_A_RDREQ 8'h18
`define MBCPB_A_WRREQ 8'h1c
`define MBCPB_A_WDATA 8'h20
`define MBCPB_A_STAT 8'h24
`define MBCPB_A_VAL 8'h28
`define MBCPB_NOUT 4
`define MBCPB_NRST 6
`define MBCPB_NVAL 19
`define MBCPB_LAST_IDX 5'h12
`define MBCPB_POLL_RST 19'h7ffff
`define MBCPB_TERM_RST 19'h00000
`define MBCPB_RDLY_RST 1'b1
`define MBCPB_MAN_RST 4'h0
`define MBCPB_ST_RESP 0
`define MBCPB_ST_BUSY 1
`define MBCPB_ST_INIT 2
`define MBCPB_OP_READ 3'h0
`define MBCPB_OP_WRITE 3'h1
`define MBCPB_OP_RESET 3'h2
`define MBCPB_OP_SETOUT 3'h3
`define MBCPB_CH_DOLLAR 8'h24
`define MBCPB_CH_STAR 8'h2a
`endif

// ### rtl/mbcpb_bridge.v
/*
  Coil logic of the fieldbus gateway: an APB register file holding the coils,
  and a sequencer that issues read, write, reset and output commands to the
  panel meter one at a time. Assumes the meter side holds mrsp_valid high for
  one cycle when the command on mreq_* is done, and that the nonvolatile store
  presents its image on nv_* at reset release.
*/
`timescale 1ns/1ps
`include "mbcpb_consts.vh"
module mbcpb_bridge (
  // Clock, reset and clock enable.
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Command port to the meter.
  output reg mreq_valid,
  output reg [2:0] mreq_op,
  output reg [4:0] mreq_idx,
  output reg [15:0] mreq_data,
  output reg [7:0] mreq_term,
  input wire mrsp_valid,
  input wire [15:0] mrsp_data,
  // Nonvolatile store of the persistent coils.
  input wire nv_valid,
  input wire [18:0] nv_poll_in,
  input wire nv_rdly_in,
  output reg nv_save,
  output reg [18:0] nv_poll_out,
  output reg nv_rdly_out
);
  localparam S_IDLE = 1'b0;
  localparam S_WAIT = 1'b1;
  localparam J_FETCH = 2'h0;
  localparam J_MBRD = 2'h1;
  localparam J_MBWR = 2'h2;
  localparam J_OTHER = 2'h3;

  reg state_r;
  reg [1:0] job_r;
  reg nv_done_r;
  reg init_done_r;
  reg [4:0] init_ptr_r;
  reg [4:0] poll_ptr_r;
  reg [18:0] term_r;
  reg [3:0] manual_mode_word_r;
  reg [3:0] out_state_r;
  reg [3:0] out_want_r;
  reg out_pend_r;
  reg [5:0] rst_pend_r;
  reg [2:0] rst_idx_r;
  reg mb_rd_pend_r;
  reg mb_wr_pend_r;
  reg mb_wait_r;
  reg resp_ready_r;
  reg [4:0] mb_idx_r;
  reg [15:0] mb_data_r;
  reg [15:0] vals_r [0:18];

  wire acc = psel & penable & ce;
  wire wr_now = acc & pready & pwrite;
  wire mb_busy = mb_rd_pend_r | mb_wr_pend_r;
  wire idx_ok = (pwdata[4:0] <= `MBCPB_LAST_IDX);
  wire rd_req = wr_now & (paddr == `MBCPB_A_RDREQ) & ~mb_busy & idx_ok;
  wire wr_req = wr_now & (paddr == `MBCPB_A_WRREQ) & ~mb_busy & idx_ok;
  wire done = (state_r == S_WAIT) & mrsp_valid;
  wire [5:0] rst_set = (wr_now & (paddr == `MBCPB_A_RST)) ? pwdata[5:0] : 6'h00;
  reg [5:0] rst_clr;
  reg [2:0] rst_low;
  reg [31:0] rd_mux;
  reg hit;
  integer i;

  // Lowest pending reset coil is served first.
  always @* begin
    rst_low = 3'h0;
    for (i = `MBCPB_NRST - 1; i >= 0; i = i - 1) begin
      if (rst_pend_r[i]) begin
        rst_low = i[2:0];
      end
    end
    rst_clr = 6'h00;
    if (done && job_r == J_OTHER && mreq_op == `MBCPB_OP_RESET) begin
      rst_clr[rst_idx_r] = 1'b1;
    end
  end

  always @* begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `MBCPB_A_OUT: rd_mux = {28'h0000000, out_state_r};
      `MBCPB_A_RST: rd_mux = 32'h0000_0000;
      `MBCPB_A_POLL: rd_mux = {13'h0000, nv_poll_out};
      `MBCPB_A_TERM: rd_mux = {13'h0000, term_r};
      `MBCPB_A_CTRL: rd_mux = {31'h00000000, nv_rdly_out};
      `MBCPB_A_MAN: rd_mux = {28'h0000000, manual_mode_word_r};
      `MBCPB_A_RDREQ: rd_mux = {27'h0000000, mb_idx_r};
      `MBCPB_A_WRREQ: rd_mux = {27'h0000000, mb_idx_r};
      `MBCPB_A_WDATA: rd_mux = {16'h0000, mb_data_r};
      `MBCPB_A_STAT: rd_mux = {29'h00000000, init_done_r, mb_busy, resp_ready_r};
      `MBCPB_A_VAL: rd_mux = {16'h0000, vals_r[mb_idx_r]};
      default: hit = 1'b0;
    endcase
  end

  // APB slave: one wait state, writes take effect at the edge pready is seen.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~hit;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Coil registers and persistent image.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_done_r <= 1'b0;
      nv_save <= 1'b0;
      nv_poll_out <= `MBCPB_POLL_RST;
      nv_rdly_out <= `MBCPB_RDLY_RST;
      term_r <= `MBCPB_TERM_RST;
      manual_mode_word_r <= `MBCPB_MAN_RST;
      out_want_r <= 4'h0;
      out_pend_r <= 1'b0;
      rst_pend_r <= 6'h00;
      mb_idx_r <= 5'h00;
      mb_data_r <= 16'h0000;
    end else if (ce) begin
      nv_save <= 1'b0;
      if (!nv_done_r) begin
        nv_done_r <= 1'b1;
        if (nv_valid) begin
          nv_poll_out <= nv_poll_in;
          nv_rdly_out <= nv_rdly_in;
        end
      end else if (wr_now && paddr == `MBCPB_A_POLL) begin
        nv_poll_out <= pwdata[18:0];
        nv_save <= 1'b1;
      end else if (wr_now && paddr == `MBCPB_A_CTRL) begin
        nv_rdly_out <= pwdata[0];
        nv_save <= 1'b1;
      end
      if (wr_now && paddr == `MBCPB_A_TERM) begin
        term_r <= pwdata[18:0];
      end
      if (wr_now && paddr == `MBCPB_A_MAN) begin
        manual_mode_word_r <= pwdata[3:0];
      end
      if (wr_now && paddr == `MBCPB_A_OUT) begin
        // Only outputs in manual mode follow the write.
        out_want_r <= (out_state_r & ~manual_mode_word_r) |
          (pwdata[3:0] & manual_mode_word_r);
        out_pend_r <= 1'b1;
      end else if (done && job_r == J_OTHER && mreq_op == `MBCPB_OP_SETOUT) begin
        out_pend_r <= 1'b0;
      end
      rst_pend_r <= (rst_pend_r & ~rst_clr) | rst_set;
      if (wr_now && paddr == `MBCPB_A_WDATA && !mb_busy) begin
        mb_data_r <= pwdata[15:0];
      end
      if (rd_req || wr_req) begin
        mb_idx_r <= pwdata[4:0];
      end
    end
  end

  // Command sequencer towards the meter.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      job_r <= J_FETCH;
      init_done_r <= 1'b0;
      init_ptr_r <= 5'h00;
      poll_ptr_r <= 5'h00;
      out_state_r <= 4'h0;
      rst_idx_r <= 3'h0;
      mb_rd_pend_r <= 1'b0;
      mb_wr_pend_r <= 1'b0;
      mb_wait_r <= 1'b0;
      resp_ready_r <= 1'b0;
      mreq_valid <= 1'b0;
      mreq_op <= `MBCPB_OP_READ;
      mreq_idx <= 5'h00;
      mreq_data <= 16'h0000;
      mreq_term <= `MBCPB_CH_DOLLAR;
    end else if (ce) begin
      if (rd_req) begin
        mb_rd_pend_r <= 1'b1;
        mb_wait_r <= ~nv_rdly_out & ~nv_poll_out[pwdata[4:0]];
        resp_ready_r <= nv_rdly_out | nv_poll_out[pwdata[4:0]];
      end
      if (wr_req) begin
        mb_wr_pend_r <= 1'b1;
        mb_wait_r <= ~nv_rdly_out;
        resp_ready_r <= nv_rdly_out;
      end
      case (state_r)
        S_IDLE: begin
          mreq_data <= 16'h0000;
          mreq_term <= `MBCPB_CH_DOLLAR;
          if (rst_pend_r != 6'h00) begin
            mreq_valid <= 1'b1;
            mreq_op <= `MBCPB_OP_RESET;
            mreq_idx <= {2'b00, rst_low};
            rst_idx_r <= rst_low;
            job_r <= J_OTHER;
            state_r <= S_WAIT;
          end else if (out_pend_r) begin
            mreq_valid <= 1'b1;
            mreq_op <= `MBCPB_OP_SETOUT;
            mreq_idx <= 5'h00;
            mreq_data <= {12'h000, out_want_r};
            job_r <= J_OTHER;
            state_r <= S_WAIT;
          end else if (mb_wr_pend_r) begin
            mreq_valid <= 1'b1;
            mreq_op <= `MBCPB_OP_WRITE;
            mreq_idx <= mb_idx_r;
            mreq_data <= mb_data_r;
            mreq_term <= term_r[mb_idx_r] ? `MBCPB_CH_STAR : `MBCPB_CH_DOLLAR;
            job_r <= J_MBWR;
            state_r <= S_WAIT;
          end else if (mb_rd_pend_r) begin
            mreq_valid <= 1'b1;
            mreq_op <= `MBCPB_OP_READ;
            mreq_idx <= mb_idx_r;
            job_r <= J_MBRD;
            state_r <= S_WAIT;
          end else if (!init_done_r) begin
            mreq_valid <= 1'b1;
            mreq_op <= `MBCPB_OP_READ;
            mreq_idx <= init_ptr_r;
            job_r <= J_FETCH;
            state_r <= S_WAIT;
            if (init_ptr_r == `MBCPB_LAST_IDX) begin
              init_done_r <= 1'b1;
            end else begin
              init_ptr_r <= init_ptr_r + 5'h01;
            end
          end else begin
            // Disabled values are skipped one per cycle; the loop wraps.
            poll_ptr_r <= (poll_ptr_r == `MBCPB_LAST_IDX) ? 5'h00 :
              poll_ptr_r + 5'h01;
            if (nv_poll_out[poll_ptr_r]) begin
              mreq_valid <= 1'b1;
              mreq_op <= `MBCPB_OP_READ;
              mreq_idx <= poll_ptr_r;
              job_r <= J_FETCH;
              state_r <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (mrsp_valid) begin
            mreq_valid <= 1'b0;
            state_r <= S_IDLE;
            if (mreq_op == `MBCPB_OP_SETOUT) begin
              out_state_r <= mreq_data[3:0];
            end
            if (job_r == J_MBWR) begin
              mb_wr_pend_r <= 1'b0;
              // Without response delay the value is read back before answering.
              if (mb_wait_r) begin
                mb_rd_pend_r <= 1'b1;
              end
            end
            if (job_r == J_MBRD) begin
              mb_rd_pend_r <= 1'b0;
              if (mb_wait_r) begin
                resp_ready_r <= 1'b1;
              end
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Value cache refreshed by every completed read.
  always @(posedge pclk) begin
    if (ce && done && mreq_op == `MBCPB_OP_READ) begin
      vals_r[mreq_idx] <= mrsp_data;
    end
  end
endmodule // mbcpb_bridge

// ### bench/mbcpb_chk.sv
/* Port checker of the bridge.
   Bound to mbcpb_bridge by the bench top. */
`timescale 1ns/1ps
`include "mbcpb_consts.vh"
module mbcpb_chk (
  // Bridge ports.
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire mreq_valid,
  input wire [2:0] mreq_op,
  input wire [4:0] mreq_idx,
  input wire [7:0] mreq_term,
  input wire mrsp_valid,
  input wire nv_save
);
  logic [18:0] term_r;
  wire wr_ok = ce && psel && penable && pwrite && pready;
  always @(posedge pclk or negedge presetn)
    if (!presetn) term_r <= `MBCPB_TERM_RST;
    else if (wr_ok && paddr == `MBCPB_A_TERM) term_r <= pwdata[18:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("no ready");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("err");
  chk_rst_zero: assert property (pready && !pwrite && paddr == `MBCPB_A_RST |->
    prdata == 32'h0) else $error("reset coil");
  chk_cmd_hold: assert property (mreq_valid && !mrsp_valid |=>
    mreq_valid && $stable({mreq_op, mreq_idx, mreq_term})) else $error("cmd moved");
  chk_cmd_end: assert property (ce && mreq_valid && mrsp_valid |=> !mreq_valid)
    else $error("end");
  chk_ce_freeze: assert property (!ce |=> $stable({mreq_valid, mreq_op, mreq_idx, mreq_term,
    pready, prdata, nv_save})) else $error("moved while frozen");
  chk_term_char: assert property (mreq_valid && mreq_op == `MBCPB_OP_WRITE |->
    mreq_term == (term_r[mreq_idx] ? `MBCPB_CH_STAR : `MBCPB_CH_DOLLAR)) else $error("term");
  chk_nv_save: assert property (wr_ok && (paddr == `MBCPB_A_POLL ||
    paddr == `MBCPB_A_CTRL) |-> ##[1:2] nv_save) else $error("no save");
  chk_boot_fetch: assert property ($rose(presetn) |-> ##[1:3] mreq_valid &&
    mreq_op == `MBCPB_OP_READ && mreq_idx == 5'h0) else $error("no boot fetch");
  chk_rst_cmd: assert property (wr_ok && paddr == `MBCPB_A_RST && pwdata[5:0] != 6'h0
    |-> ##[1:60] mreq_valid && mreq_op == `MBCPB_OP_RESET) else $error("no reset cmd");
  cover property (mreq_valid && mrsp_valid && mreq_op == `MBCPB_OP_WRITE);
  cover property (pslverr);
  cover property (nv_save);
endmodule // mbcpb_chk

// ### bench/mbcpb_meter.sv
/* Meter model: answers each command lat+1 cycles after it appears.
   Its data lines toggle between answers so stale values show. */
`timescale 1ns/1ps
module mbcpb_meter (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Command port.
  input wire mreq_valid,
  input wire [4:0] mreq_idx,
  input wire [3:0] lat,
  output logic mrsp_valid,
  output logic [15:0] mrsp_data
);
  logic [3:0] cnt;
  logic [10:0] gen;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      gen <= 11'h0;
      mrsp_valid <= 1'b0;
      mrsp_data <= 16'h0;
    end else begin
      mrsp_valid <= 1'b0;
      mrsp_data <= ~mrsp_data;
      if (mreq_valid && !mrsp_valid) begin
        cnt <= cnt + 4'h1;
        if (cnt >= lat) begin
          cnt <= 4'h0;
          gen <= gen + 11'h1;
          mrsp_valid <= 1'b1;
          mrsp_data <= {mreq_idx, gen};
        end
      end
    end
  end
endmodule // mbcpb_meter

// ### bench/mbcpb_bridge_tb_top.sv
/* Bench top: bridge, meter model and checker bind.
   Self-checking; ends with a verdict line. */
`timescale 1ns/1ps
`include "mbcpb_consts.vh"
module mbcpb_bridge_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nv_valid, nv_save;
  logic nv_rdly_out, mreq_valid, mrsp_valid, e, loop_on, have_prev, ce;
  logic [7:0] paddr, mreq_term, wr_term;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] mreq_op;
  logic [4:0] mreq_idx, prev_idx;
  logic [15:0] mreq_data, mrsp_data, out_data, wr_dat, wv;
  logic [18:0] nv_poll_out, seen, m;
  logic [15:0] last_val [0:18];
  logic [5:0] rst_seen;
  logic [3:0] lat, mm, ww, exp_out;
  int fail_count, check_count, cyc;
  mbcpb_bridge u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mreq_valid, .mreq_op, .mreq_idx, .mreq_data, .mreq_term,
    .mrsp_valid, .mrsp_data, .nv_valid, .nv_poll_in(m), .nv_rdly_in(1'b0), .nv_save,
    .nv_poll_out, .nv_rdly_out);
  mbcpb_meter u_meter (.pclk, .presetn, .mreq_valid, .mreq_idx, .lat, .mrsp_valid, .mrsp_data);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("fails %0d checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [4:0] nxt(input logic [4:0] i);
    logic [4:0] j;
    j = i;
    repeat (19) begin
      j = (j == `MBCPB_LAST_IDX) ? 5'h0 : j + 5'h1;
      if (m[j]) return j;
    end
    return i;
  endfunction
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      stop_test;
    end
    if (ce && mreq_valid && mrsp_valid) begin
      case (mreq_op)
        `MBCPB_OP_READ: begin
          seen[mreq_idx] <= 1'b1;
          last_val[mreq_idx] <= mrsp_data;
          if (loop_on && have_prev) check(mreq_idx, nxt(prev_idx));
          prev_idx <= mreq_idx;
          have_prev <= loop_on;
        end
        `MBCPB_OP_WRITE: {wr_term, wr_dat} <= {mreq_term, mreq_data};
        `MBCPB_OP_RESET: rst_seen[mreq_idx] <= 1'b1;
        default: out_data <= mreq_data;
      endcase
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_bit(input int b, input logic v);
    for (int n = 0; n < 100; n++) begin
      apb(1'b0, `MBCPB_A_STAT, 32'h0);
      if (r[b] === v) return;
    end
    fail_count++;
  endtask
  task automatic boot(input logic nv);
    presetn <= 1'b0;
    nv_valid <= nv;
    repeat (20) @(posedge pclk);
    seen <= 19'h0;
    presetn <= 1'b1;
  endtask
  initial begin
    void'($urandom(32'hd74867d5));
    {psel, penable, pwrite, paddr, pwdata, presetn, nv_valid, loop_on, have_prev} = '0;
    {rst_seen, lat} = '0;
    ce = 1'b1;
    m = 19'($urandom);
    m[3] = 1'b0;
    m[18] = 1'b1;
    boot(1'b0);
    apb(1'b0, `MBCPB_A_POLL, 32'h0);
    check(r, `MBCPB_POLL_RST);
    apb(1'b0, `MBCPB_A_CTRL, 32'h0);
    check(r, `MBCPB_RDLY_RST);
    apb(1'b0, 8'h3c, 32'h0);
    check(e, 1'b1);
    boot(1'b1);
    apb(1'b0, `MBCPB_A_POLL, 32'h0);
    check(r, m);
    check(nv_rdly_out, 1'b0);
    wait_bit(`MBCPB_ST_INIT, 1'b1);
    repeat (2) @(posedge pclk);
    check(seen, 19'h7ffff);
    loop_on <= 1'b1;
    repeat (100) @(posedge pclk);
    // The loop must resume in order after a stretch with the clock enable low.
    ce <= 1'b0;
    repeat (16) @(posedge pclk);
    ce <= 1'b1;
    repeat (200) @(posedge pclk);
    loop_on <= 1'b0;
    lat <= 4'd12;
    wait_bit(`MBCPB_ST_BUSY, 1'b0);
    apb(1'b1, `MBCPB_A_RDREQ, 32'h3);
    apb(1'b0, `MBCPB_A_STAT, 32'h0);
    check(r[0], 1'b0);
    wait_bit(`MBCPB_ST_RESP, 1'b1);
    apb(1'b0, `MBCPB_A_VAL, 32'h0);
    check(r, last_val[3]);
    for (int t = 0; t < 2; t++) begin
      wait_bit(`MBCPB_ST_BUSY, 1'b0);
      apb(1'b1, `MBCPB_A_TERM, 32'(t) << 3);
      wv = 16'($urandom);
      apb(1'b1, `MBCPB_A_WDATA, {16'h0000, wv});
      seen <= 19'h0;
      apb(1'b1, `MBCPB_A_WRREQ, 32'h3);
      apb(1'b0, `MBCPB_A_STAT, 32'h0);
      check(r[0], 1'b0);
      wait_bit(`MBCPB_ST_RESP, 1'b1);
      check(seen[3], 1'b1);
      check(wr_term, t ? `MBCPB_CH_STAR : `MBCPB_CH_DOLLAR);
      check(wr_dat, wv);
    end
    apb(1'b1, `MBCPB_A_CTRL, 32'h1);
    check(nv_rdly_out, 1'b1);
    wait_bit(`MBCPB_ST_BUSY, 1'b0);
    apb(1'b1, `MBCPB_A_RDREQ, 32'h3);
    apb(1'b0, `MBCPB_A_STAT, 32'h0);
    check(r[0], 1'b1);
    lat <= 4'd1;
    for (int j = 0; j < 6; j++) begin
      apb(1'b1, `MBCPB_A_RST, 32'h1 << j);
      apb(1'b0, `MBCPB_A_RST, 32'h0);
      check(r, 32'h0);
    end
    for (int n = 0; n < 300 && rst_seen !== 6'h3f; n++) @(posedge pclk);
    check(rst_seen, 6'h3f);
    // First round sets every output; the second must leave non-manual ones alone.
    exp_out = 4'h0;
    for (int t = 0; t < 2; t++) begin
      mm = t ? ((4'($urandom) & 4'h7) | 4'h1) : 4'hf;
      ww = t ? 4'($urandom) : (4'($urandom) | 4'h8);
      exp_out = (exp_out & ~mm) | (ww & mm);
      out_data <= 16'hffff;
      apb(1'b1, `MBCPB_A_MAN, 32'(mm));
      apb(1'b1, `MBCPB_A_OUT, 32'(ww));
      for (int n = 0; n < 300 && out_data === 16'hffff; n++) @(posedge pclk);
      check(out_data, exp_out);
      apb(1'b0, `MBCPB_A_OUT, 32'h0);
      check(r, exp_out);
    end
    m = ~m;
    apb(1'b1, `MBCPB_A_POLL, {13'h0000, m});
    check(nv_poll_out, m);
    stop_test;
  end
endmodule // mbcpb_bridge_tb_top
bind mbcpb_bridge mbcpb_chk u_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .mreq_valid, .mreq_op, .mreq_idx, .mreq_term,
  .mrsp_valid, .nv_save);
